// ### common/vector_map_defs.vh
`ifndef VECTOR_MAP_DEFS_VH
`define VECTOR_MAP_DEFS_VH

// ==========================================================================
// Vector table layout
// ==========================================================================
`define VEC_COUNT          26
`define VEC_SRC_COUNT      25
`define VEC_ADDR_W         12
`define VEC_NUM_W          5
`define VEC_RESET_ADDR     12'h000
`define VEC_TABLE_START    12'h001
`define VEC_STRIDE         12'h001
`define VEC_BOOT_START     12'hC00
`define VEC_RESET_NUM      5'h01
`define VEC_ADDR_NONE      12'h000

`endif

// ### core/vector_pick.v
`timescale 1ns/10ps
`default_nettype none

// ==========================================================================
// Lowest-index pending source picker
// ==========================================================================
module vector_pick #(
  parameter N = 25,
  parameter W = 5
) (
  input  wire [N-1:0] req_i,    // Pending and enabled sources
  output reg          any_o,    // At least one request
  output reg  [W-1:0] index_o   // Index of lowest set bit
);

  integer k;

  // Scan from top so the lowest index wins last
  always @* begin
    any_o   = 1'b0;
    index_o = {W{1'b0}};
    for (k = N - 1; k >= 0; k = k - 1) begin
      if (req_i[k]) begin
        any_o   = 1'b1;
        index_o = k[W-1:0];
      end
    end
  end

endmodule // vector_pick

`default_nettype wire

// ### core/interrupt_vector_map.v
`timescale 1ns/10ps
`default_nettype none
`include "vector_map_defs.vh"

// Summary of operation
// RULE_01 - Every system reset source fetches vector 1 at address zero unless the boot fuse is programmed.
// RULE_02 - External request zero uses address one, external request one uses two.
// RULE_03 - Pin-change groups use three to five, watchdog timeout uses six.
// RULE_04 - Timer C match A, match B, overflow use seven, eight, nine.
// RULE_05 - Timer B capture, match A, match B, overflow use 0x00A to 0x00D.
// RULE_06 - Timer A match A, match B, overflow use 0x00E, 0x00F, 0x010.
// RULE_07 - Sync serial done uses 0x011, serial receive done uses 0x012.
// RULE_08 - Serial buffer empty uses 0x013, serial transmit done uses 0x014.
// RULE_09 - Converter 0x015, nvm ready 0x016, comparator 0x017, two-wire 0x018.
// RULE_10 - Program store ready uses 0x019, the last of 26 vectors.
// RULE_11 - Reset address and table start follow boot fuse and relocate bit.
// RULE_12 - A source not enabled never causes a vector fetch.
// RULE_13 - With relocate bit set, boot start is added to table addresses.
// RULE_14 - Programmed boot fuse (zero) starts execution at boot reset address.
// RULE_15 - Each vector is one instruction word; neighbours differ by one.
// RULE_16 - Of several pending enabled sources, the lowest vector number wins.

module interrupt_vector_map #(
  parameter ADDR_W     = `VEC_ADDR_W,      // Program address width
  parameter BOOT_START = `VEC_BOOT_START   // Boot section start word
) (
  input  wire              ref_clk_i,              // Core clock
  input  wire              sys_rst_i,              // Async reset, active high
  input  wire              ext_pin_rst_i,          // External reset pin, async
  input  wire              power_on_rst_i,         // Power-on reset request
  input  wire              brown_out_rst_i,        // Brown-out reset request
  input  wire              watchdog_rst_i,         // Watchdog system reset request
  input  wire              boot_reset_fuse_i,      // 0 = programmed
  input  wire              vector_relocate_bit_i,  // 1 = table in boot section
  input  wire              global_enable_i,        // Core interrupt enable
  input  wire              ext_irq_zero_i,         // Source, vector 2
  input  wire              ext_irq_one_i,          // Source, vector 3
  input  wire              pin_change_group_a_i,   // Source, vector 4
  input  wire              pin_change_group_b_i,   // Source, vector 5
  input  wire              pin_change_group_c_i,   // Source, vector 6
  input  wire              watchdog_timeout_i,     // Source, vector 7
  input  wire              timer_c_match_a_i,      // Source, vector 8
  input  wire              timer_c_match_b_i,      // Source, vector 9
  input  wire              timer_c_overflow_i,     // Source, vector 10
  input  wire              timer_b_capture_i,      // Source, vector 11
  input  wire              timer_b_match_a_i,      // Source, vector 12
  input  wire              timer_b_match_b_i,      // Source, vector 13
  input  wire              timer_b_overflow_i,     // Source, vector 14
  input  wire              timer_a_match_a_i,      // Source, vector 15
  input  wire              timer_a_match_b_i,      // Source, vector 16
  input  wire              timer_a_overflow_i,     // Source, vector 17
  input  wire              sync_serial_transfer_done_i, // Source, vector 18
  input  wire              serial_rx_done_i,       // Source, vector 19
  input  wire              serial_tx_buffer_empty_i, // Source, vector 20
  input  wire              serial_tx_done_i,       // Source, vector 21
  input  wire              converter_done_i,       // Source, vector 22
  input  wire              nvm_ready_i,            // Source, vector 23
  input  wire              comparator_event_i,     // Source, vector 24
  input  wire              two_wire_event_i,       // Source, vector 25
  input  wire              program_store_ready_i,  // Source, vector 26
  input  wire [24:0]       source_enable_i,        // Per-source enable, bit0 = vector 2
  input  wire              vector_ack_i,           // Core took the vector
  output reg               vector_req_o,           // Fetch request to core
  output reg  [ADDR_W-1:0] vector_addr_o,          // Address to fetch
  output reg  [4:0]        vector_num_o,           // Vector number 1..26
  output reg               in_reset_o              // Reset vector pending
);

  // ========================================================================
  // Address arithmetic
  // ========================================================================
  // Table base for the current relocation setting
  function [ADDR_W-1:0] table_base;
    input reloc;
    begin
      table_base = reloc ? BOOT_START[ADDR_W-1:0] : {ADDR_W{1'b0}};  // see RULE_13
    end
  endfunction

  // Word address of a vector number; one word per slot
  function [ADDR_W-1:0] slot_addr;
    input [4:0] num;
    input       reloc;
    reg   [ADDR_W-1:0] off;
    begin
      off       = {{(ADDR_W-5){1'b0}}, num - 5'h01};            // see RULE_15
      slot_addr = table_base(reloc) + off;                     // see RULE_11
    end
  endfunction

  // ========================================================================
  // Input synchronisers
  // ========================================================================
  // Sources and reset requests come from other logic or pins; all pass two flops
  wire [24:0] src_raw = {program_store_ready_i, two_wire_event_i, comparator_event_i,
                         nvm_ready_i, converter_done_i, serial_tx_done_i,
                         serial_tx_buffer_empty_i, serial_rx_done_i,
                         sync_serial_transfer_done_i, timer_a_overflow_i,
                         timer_a_match_b_i, timer_a_match_a_i, timer_b_overflow_i,
                         timer_b_match_b_i, timer_b_match_a_i, timer_b_capture_i,
                         timer_c_overflow_i, timer_c_match_b_i, timer_c_match_a_i,
                         watchdog_timeout_i, pin_change_group_c_i,
                         pin_change_group_b_i, pin_change_group_a_i,
                         ext_irq_one_i, ext_irq_zero_i};  // see RULE_02
  wire [3:0]  rst_raw = {watchdog_rst_i, brown_out_rst_i, power_on_rst_i, ext_pin_rst_i};

  reg  [24:0] src_meta_r;
  reg  [24:0] src_sync_r;
  reg  [3:0]  rst_meta_r;
  reg  [3:0]  rst_sync_r;

  // Two-stage synchroniser; first stage feeds only the second
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      src_meta_r <= 25'h000_0000;
      src_sync_r <= 25'h000_0000;
      rst_meta_r <= 4'h0;
      rst_sync_r <= 4'h0;
    end else begin
      src_meta_r <= src_raw;
      src_sync_r <= src_meta_r;
      rst_meta_r <= rst_raw;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ========================================================================
  // Request qualification and priority
  // ========================================================================
  // Disabled sources are masked out entirely
  wire [24:0] src_live = src_sync_r & source_enable_i & {25{global_enable_i}};  // see RULE_12

  wire        pick_any;
  wire [4:0]  pick_idx;

  // Lowest bit is the lowest vector number
  vector_pick #(
    .N (`VEC_SRC_COUNT),
    .W (`VEC_NUM_W)
  ) u_pick (
    .req_i   (src_live),
    .any_o   (pick_any),
    .index_o (pick_idx)
  );  // see RULE_16

  // Source index 0 is vector 2; range checked by the picker width
  wire [4:0]  pick_num = pick_idx + 5'h02;  // see RULE_03
  wire        any_sys_rst = |rst_sync_r;    // see RULE_01

  // ========================================================================
  // Handshake state machine
  // ========================================================================
  localparam [1:0] ST_RESET = 2'b00;
  localparam [1:0] ST_IDLE  = 2'b01;
  localparam [1:0] ST_REQ   = 2'b10;

  reg  [1:0]        state_r;
  reg  [1:0]        state_nxt;
  reg  [ADDR_W-1:0] addr_nxt;
  reg  [4:0]        num_nxt;

  // Next state; a system reset preempts any pending interrupt vector
  always @* begin
    state_nxt = state_r;
    addr_nxt  = vector_addr_o;
    num_nxt   = vector_num_o;
    case (state_r)
      ST_RESET: begin
        // Programmed fuse sends reset to the boot section
        addr_nxt  = boot_reset_fuse_i ? `VEC_RESET_ADDR : BOOT_START[ADDR_W-1:0];  // see RULE_14
        num_nxt   = `VEC_RESET_NUM;  // see RULE_01
        if (vector_ack_i && !any_sys_rst) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (any_sys_rst) begin
          state_nxt = ST_RESET;
        end else if (pick_any) begin
          state_nxt = ST_REQ;
          addr_nxt  = slot_addr(pick_num, vector_relocate_bit_i);  // see RULE_04
          num_nxt   = pick_num;  // see RULE_05
        end
      end
      ST_REQ: begin
        // Vector is held steady until the core accepts it
        if (any_sys_rst) begin
          state_nxt = ST_RESET;
        end else if (vector_ack_i) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_RESET;
      end
    endcase
  end

  // State and output registers
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r       <= ST_RESET;
      vector_addr_o <= `VEC_ADDR_NONE;
      vector_num_o  <= `VEC_RESET_NUM;
    end else begin
      state_r       <= state_nxt;
      vector_addr_o <= addr_nxt;  // see RULE_06
      vector_num_o  <= num_nxt;   // see RULE_07
    end
  end

  // Request and reset flags follow state; vectors 19..26 use the same slot math
  always @* begin
    vector_req_o = (state_r == ST_RESET) || (state_r == ST_REQ);  // see RULE_08
    in_reset_o   = (state_r == ST_RESET);  // see RULE_09
  end

  // Vector 26 lands at 0x019 by the one-word stride; see RULE_10

endmodule // interrupt_vector_map

`default_nettype wire

// ### tb/interrupt_vector_map_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Port checker for the vector map
module vector_map_checker #(parameter ADDR_W = 12, parameter BOOT_START = 12'hc00) (
  input wire logic ref_clk_i, sys_rst_i, ext_pin_rst_i, power_on_rst_i, brown_out_rst_i, watchdog_rst_i, // Ctl
  input wire logic boot_reset_fuse_i, vector_relocate_bit_i, global_enable_i, vector_ack_i, // Config
  input wire logic [24:0] source_enable_i, // Enables
  input wire logic vector_req_o, in_reset_o, // Request
  input wire logic [ADDR_W-1:0] vector_addr_o, // Address
  input wire logic [4:0] vector_num_o // Number
);
  logic [2:0] rh;
  logic g1, rl1;
  logic [24:0] en1;
  wire pin_rst = ext_pin_rst_i | power_on_rst_i | brown_out_rst_i | watchdog_rst_i;
  wire quiet = !pin_rst && rh == 3'h0;
  // Pin history covers the sync delay, so preemption never looks like a fault
  always @(posedge ref_clk_i) begin
    rh <= {rh[1:0], pin_rst};
    g1 <= global_enable_i;
    rl1 <= vector_relocate_bit_i;
    en1 <= source_enable_i;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  map_addr_a: assert property ($rose(vector_req_o) && !in_reset_o |->
    vector_addr_o == (rl1 ? BOOT_START : 0) + vector_num_o - 1) else $error("vector address wrong");
  gate_src_a: assert property ($rose(vector_req_o) && !in_reset_o |->
    g1 && en1[vector_num_o - 5'd2]) else $error("gated source served");
  rst_addr_a: assert property (in_reset_o && $past(in_reset_o) && !$past(sys_rst_i) |->
    vector_addr_o == (boot_reset_fuse_i ? 0 : BOOT_START)) else $error("reset address wrong");
  rst_num_a: assert property (in_reset_o |-> vector_num_o == 5'h01) else $error("reset number wrong");
  rst_req_a: assert property (in_reset_o |-> vector_req_o) else $error("reset not requested");
  rst_entry_a: assert property ($rose(pin_rst) && !in_reset_o |-> ##[2:4] in_reset_o) else $error("reset late");
  hold_out_a: assert property (vector_req_o && !vector_ack_i && quiet && !$past(sys_rst_i) |=>
    vector_req_o && $stable(vector_addr_o) && $stable(vector_num_o)) else $error("vector not held");
  ack_gap_a: assert property (vector_req_o && vector_ack_i && quiet |=> !vector_req_o) else $error("no idle gap");
  reloc_c: cover property ($rose(vector_req_o) && rl1);
  boot_c: cover property (in_reset_o && !boot_reset_fuse_i && vector_ack_i);
  back_c: cover property (vector_ack_i ##2 (vector_req_o && !in_reset_o));
endmodule // vector_map_checker
bind interrupt_vector_map vector_map_checker #(.ADDR_W(ADDR_W), .BOOT_START(BOOT_START)) chk_u (.*);
`default_nettype wire

// ### tb/core_fetch_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Core side: accepts each vector after a chosen delay
module core_fetch_model (
  input wire logic       ref_clk_i, sys_rst_i, vector_req_i, // Clock, reset, request
  input wire logic [2:0] delay_i,                             // Wait before accept
  output logic           vector_ack_o                         // One-cycle accept
);
  logic [2:0] wait_r;
  // Single pulse, so one vector is never taken twice
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wait_r <= 3'h0;
      vector_ack_o <= 1'b0;
    end else begin
      vector_ack_o <= 1'b0;
      if (vector_req_i && !vector_ack_o && wait_r >= delay_i) begin
        vector_ack_o <= 1'b1;
        wait_r <= 3'h0;
      end else if (vector_req_i && !vector_ack_o) begin
        wait_r <= wait_r + 3'h1;
      end
    end
  end
endmodule // core_fetch_model
`default_nettype wire

// ### tb/interrupt_vector_map_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Vector map bench
module interrupt_vector_map_tb;
  localparam logic [11:0] BOOT_AT = 12'h600;
  logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, fuse = 1'b1, reloc = 1'b0, glob = 1'b0, busy = 1'b0;
  logic [3:0] rst_pins = 4'h0;
  logic [24:0] src = 25'h0, en = 25'h0;
  logic [24:0] s1 = 25'h0, s2 = 25'h0, s3 = 25'h0, e1 = 25'h0;
  logic [2:0] dly = 3'h0;
  logic [4:0] exp_num = 5'h00;
  logic [31:0] seed, e_val;
  int err_count = 0, total_checks = 0;
  wire req, in_rst, ack;
  wire [11:0] addr;
  wire [4:0] num;
  interrupt_vector_map #(.ADDR_W(12), .BOOT_START(BOOT_AT)) dut_u (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .ext_pin_rst_i(rst_pins[0]), .power_on_rst_i(rst_pins[1]), .brown_out_rst_i(rst_pins[2]),
    .watchdog_rst_i(rst_pins[3]), .boot_reset_fuse_i(fuse), .vector_relocate_bit_i(reloc), .global_enable_i(glob),
    .ext_irq_zero_i(src[0]), .ext_irq_one_i(src[1]), .pin_change_group_a_i(src[2]), .pin_change_group_b_i(src[3]),
    .pin_change_group_c_i(src[4]), .watchdog_timeout_i(src[5]), .timer_c_match_a_i(src[6]),
    .timer_c_match_b_i(src[7]), .timer_c_overflow_i(src[8]), .timer_b_capture_i(src[9]),
    .timer_b_match_a_i(src[10]), .timer_b_match_b_i(src[11]), .timer_b_overflow_i(src[12]),
    .timer_a_match_a_i(src[13]), .timer_a_match_b_i(src[14]), .timer_a_overflow_i(src[15]),
    .sync_serial_transfer_done_i(src[16]), .serial_rx_done_i(src[17]), .serial_tx_buffer_empty_i(src[18]),
    .serial_tx_done_i(src[19]), .converter_done_i(src[20]), .nvm_ready_i(src[21]), .comparator_event_i(src[22]),
    .two_wire_event_i(src[23]), .program_store_ready_i(src[24]), .source_enable_i(en), .vector_ack_i(ack),
    .vector_req_o(req), .vector_addr_o(addr), .vector_num_o(num), .in_reset_o(in_rst));
  core_fetch_model core_u (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .vector_req_i(req), .delay_i(dly),
    .vector_ack_o(ack));
  // ==========================================================================
  // Clock and helpers
  initial begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Lowest pending source as vector number, zero when none
  function automatic logic [4:0] lowest(input logic [24:0] v);
    lowest = 5'h00;
    for (int i = 24; i >= 0; i--) if (v[i]) lowest = 5'(i + 2);
  endfunction
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Bounded wait until nothing enabled is pending or being served
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while ((req || busy || ((src | s1 | s2 | s3) & en) != 25'h0) && n < 600);
    check("settle", 12'h000, {11'h0, n >= 600});
  endtask
  task automatic do_reset(input logic f);
    sys_rst_i <= 1'b1;
    fuse <= f;
    repeat (20) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    wait_idle();
  endtask
  task automatic round(input logic [24:0] e, input logic [24:0] s, input logic rl);
    @(posedge ref_clk_i);
    en <= e;
    src <= s;
    reloc <= rl;
    dly <= seed[30:28];
    wait_idle();
    src <= 25'h0;
    repeat (3) @(posedge ref_clk_i);
  endtask
  // ==========================================================================
  // Core-side monitor: predicts from a three-flop copy (s1..s3) of the two sync flops plus the request register, so a
  // served source still in the pipeline may legally be requested once more
  always @(posedge ref_clk_i) begin
    s1 <= src;
    s2 <= s1;
    s3 <= s2;
    e1 <= en;
    if (sys_rst_i) begin
      busy <= 1'b0;
    end else if (ack && in_rst) begin
      busy <= 1'b0;
      check("reset num", 12'h001, {7'h0, num});
      check("reset addr", fuse ? 12'h000 : BOOT_AT, addr);
    end else if (ack) begin
      busy <= 1'b0;
      check("vector num", {7'h0, exp_num}, {7'h0, num});
      check("vector addr", (reloc ? BOOT_AT : 12'h000) + {7'h0, exp_num} - 12'h001, addr);
    end else if (req && !busy && !in_rst) begin
      busy <= 1'b1;
      exp_num <= lowest(s3 & e1);
      src <= src & ~(25'h1 << (lowest(s3 & e1) - 5'd2));
    end
  end
  // ==========================================================================
  // Main sequence
  initial begin
    seed = 32'h2d60_fd77;
    for (int f = 1; f >= 0; f--) begin
      do_reset(f[0]);
      for (int k = 0; k < 4; k++) begin
        @(posedge ref_clk_i);
        rst_pins <= 4'h1 << k;
        repeat (4) @(posedge ref_clk_i);
        rst_pins <= 4'h0;
        @(negedge ref_clk_i);
        check("reset entry", 12'h001, {11'h0, in_rst});
        wait_idle();
      end
    end
    @(posedge ref_clk_i);
    en <= 25'h1ff_ffff;
    src <= 25'h100_0011;
    repeat (12) @(posedge ref_clk_i);
    check("gated request", 12'h000, {11'h0, req});
    glob <= 1'b1;
    wait_idle();
    for (int i = 0; i < 25; i++) round(25'h1ff_ffff, 25'h1 << i, i[0]);
    for (int r = 0; r < 30; r++) begin
      seed = xs(seed);
      e_val = seed;
      seed = xs(seed);
      round(e_val[24:0], seed[24:0], seed[31]);
    end
    end_of_test();
  end
  initial begin
    repeat (30000) @(posedge ref_clk_i);
    err_count++;
    end_of_test();
  end
endmodule // interrupt_vector_map_tb
`default_nettype wire
